/* src/mau_divider.sv */
// Iterative restoring divider, unsigned magnitudes, one bit per cycle.
// Assumes the caller holds no new start while busy.
`timescale 1ns/1ps
module mau_divider (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic i_start,
    input wire logic [31:0] i_dividend,
    input wire logic [31:0] i_divisor,
    output logic o_busy,
    output logic o_done,
    output logic [31:0] o_quotient,
    output logic [31:0] o_remainder
);
    logic [5:0] count_reg;
    logic [31:0] quot_reg;
    logic [32:0] rem_reg;
    logic [31:0] divisor_reg;
    logic [32:0] trial;

    // Shift in next dividend bit and try a subtract
    assign trial = {rem_reg[31:0], quot_reg[31]} - {1'b0, divisor_reg};

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            count_reg <= 6'h00;
            quot_reg <= 32'h0000_0000;
            rem_reg <= 33'h0_0000_0000;
            divisor_reg <= 32'h0000_0000;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (i_start && count_reg == 6'h00) begin
                count_reg <= mau_pkg::DIV_STEPS;
                quot_reg <= i_dividend;
                rem_reg <= 33'h0_0000_0000;
                divisor_reg <= i_divisor;
            end else if (count_reg != 6'h00) begin
                count_reg <= count_reg - 6'h01;
                if (!trial[32]) begin
                    rem_reg <= trial;
                    quot_reg <= {quot_reg[30:0], 1'b1};
                end else begin
                    rem_reg <= {rem_reg[31:0], quot_reg[31]};
                    quot_reg <= {quot_reg[30:0], 1'b0};
                end
                o_done <= (count_reg == 6'h01);
            end
        end
    end

    assign o_busy = (count_reg != 6'h00);
    assign o_quotient = quot_reg;
    assign o_remainder = rem_reg[31:0];
endmodule : mau_divider

/* src/mau_pkg.sv */
// Package for the multiply/divide datapath: operation codes and carriers.
// Assumes one core clock; the issue logic presents one operation at a time.
package mau_pkg;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned GPR_IDX_W = 5;
    localparam int unsigned WIDE_W = 64;
    localparam logic [31:0] RESULT_RESET = 32'h0000_0000;
    localparam logic [5:0] DIV_STEPS = 6'h20;

    typedef enum logic [3:0] {
        MAU_OP_NONE,
        MAU_OP_MULT,
        MAU_OP_MULTU,
        MAU_OP_DIV,
        MAU_OP_DIVU,
        MAU_OP_ACC,
        MAU_OP_ACCU,
        MAU_OP_DEDUCT,
        MAU_OP_DEDUCTU,
        MAU_OP_PRODUCT_GPR,
        MAU_OP_MOVE_UPPER,
        MAU_OP_MOVE_BOTTOM,
        MAU_OP_LOAD_UPPER,
        MAU_OP_LOAD_BOTTOM
    } mau_op_type;

    typedef struct packed {
        mau_op_type op;
        logic [31:0] src_a;
        logic [31:0] src_b;
        logic [4:0] dest;
    } mau_req_type;

    typedef struct packed {
        logic valid;
        logic [4:0] dest;
        logic [31:0] data;
    } mau_wb_type;
endpackage : mau_pkg

/* src/mau_unit.sv */
// Multiply/divide datapath with the upper/bottom result pair.
// Multiplies, accumulates and loads finish in one cycle; divides take 34.
// Assumes the issue logic holds i_req steady while o_busy is high and
// writes o_wb.data into general register o_wb.dest when o_wb.valid is set.
// Assumes a request counts as taken at an edge where o_busy is low; a
// divide still held in the cycle after its result lands starts again.
//
// Operation
// RULE1: multiply and divide results land in the result pair, not the registers.
// RULE2: move operations copy upper or bottom result into the chosen register.
// RULE3: three-operand multiply writes low product straight to a general register.
// RULE4: three-operand multiply may target any general register.
// RULE5: accumulate adds product to the 64-bit pair and stores the sum.
// RULE6: deduct subtracts product from the 64-bit pair and stores the difference.
// RULE7: multiply gives upper high word, bottom low; divide gives bottom quotient.
`timescale 1ns/1ps
module mau_unit (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic i_req_valid,
    input wire mau_pkg::mau_req_type i_req,
    output logic o_busy,
    output mau_pkg::mau_wb_type o_wb,
    output logic [31:0] o_upper_result,
    output logic [31:0] o_bottom_result
);
    // Result pair and its next value
    logic [31:0] upper_result_reg;
    logic [31:0] bottom_result_reg;
    logic [31:0] upper_result_next;
    logic [31:0] bottom_result_next;
    logic pair_write;

    // Product path; sum and difference are formed every cycle
    logic is_signed;
    logic [63:0] product;
    logic [63:0] pair_value;
    logic [63:0] pair_sum;
    logic [63:0] pair_diff;

    // Divider handshake and the signs kept for the fix-up
    logic div_start;
    logic div_busy;
    logic div_done;
    logic div_signed_reg;
    logic quot_neg_reg;
    logic rem_neg_reg;

    // Divider operands and results, before and after the sign fix-up
    logic [31:0] div_quot;
    logic [31:0] div_rem;
    logic [31:0] quot_fixed;
    logic [31:0] rem_fixed;
    logic [31:0] mag_a;
    logic [31:0] mag_b;

    // Operation seen this cycle; NONE when nothing is presented
    mau_pkg::mau_op_type op;

    ////////////////////////////////////////////////////////////////////////////
    // Arithmetic
    ////////////////////////////////////////////////////////////////////////////

    assign op = i_req_valid ? i_req.op : mau_pkg::MAU_OP_NONE;

    // Signed variants sign-extend both operands into a 64-bit product
    always_comb begin
        is_signed = (op == mau_pkg::MAU_OP_MULT) || (op == mau_pkg::MAU_OP_ACC) ||
                    (op == mau_pkg::MAU_OP_DEDUCT) || (op == mau_pkg::MAU_OP_PRODUCT_GPR) ||
                    (op == mau_pkg::MAU_OP_DIV);
        if (is_signed) begin
            product = 64'($signed(i_req.src_a) * $signed(i_req.src_b));
        end else begin
            // Unsigned variants zero-extend; only the high word differs
            product = {32'h0000_0000, i_req.src_a} * {32'h0000_0000, i_req.src_b};
        end
    end

    // Pair as one 64-bit accumulator, upper word on top
    assign pair_value = {upper_result_reg, bottom_result_reg};
    assign pair_sum = pair_value + product; // RULE5
    assign pair_diff = pair_value - product; // RULE6

    // Divider works on magnitudes; signs are fixed up on completion
    // Negating the most negative value gives itself, already its magnitude
    assign mag_a = (is_signed && i_req.src_a[31]) ? 32'(-i_req.src_a) : i_req.src_a;
    assign mag_b = (is_signed && i_req.src_b[31]) ? 32'(-i_req.src_b) : i_req.src_b;
    assign div_start = !div_busy && !div_done &&
                       ((op == mau_pkg::MAU_OP_DIV) || (op == mau_pkg::MAU_OP_DIVU));

    // One quotient bit per cycle keeps the divider small at the cost of latency
    mau_divider u_divider (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_start(div_start),
        .i_dividend(mag_a),
        .i_divisor(mag_b),
        .o_busy(div_busy),
        .o_done(div_done),
        .o_quotient(div_quot),
        .o_remainder(div_rem)
    );

    // Remember result signs at start; operands may change afterwards
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            div_signed_reg <= 1'b0;
            quot_neg_reg <= 1'b0;
            rem_neg_reg <= 1'b0;
        end else if (div_start) begin
            div_signed_reg <= is_signed;
            quot_neg_reg <= i_req.src_a[31] ^ i_req.src_b[31];
            rem_neg_reg <= i_req.src_a[31]; // Remainder follows the dividend
        end
    end

    // Undo the magnitudes; unsigned divides pass both words straight through
    assign quot_fixed = (div_signed_reg && quot_neg_reg) ? 32'(-div_quot) : div_quot; // RULE7
    assign rem_fixed = (div_signed_reg && rem_neg_reg) ? 32'(-div_rem) : div_rem; // RULE7

    // Stall issue from divide start until the result is in the pair.
    // Busy is already low in the done cycle, so the held divide counts
    // as taken at that edge and the next operation may follow at once.
    assign o_busy = div_start || div_busy;

    ////////////////////////////////////////////////////////////////////////////
    // Result pair
    ////////////////////////////////////////////////////////////////////////////

    // Pair next value; only pair-targeted operations touch it
    always_comb begin
        pair_write = 1'b0;
        upper_result_next = upper_result_reg;
        bottom_result_next = bottom_result_reg;
        // Divide result first; the divide is still the request in that cycle
        if (div_done) begin
            pair_write = 1'b1;
            bottom_result_next = quot_fixed; // RULE7
            upper_result_next = rem_fixed; // RULE7
        end else begin
            case (op)
                // Plain multiply replaces the whole pair
                mau_pkg::MAU_OP_MULT, mau_pkg::MAU_OP_MULTU: begin
                    pair_write = 1'b1; // RULE1
                    {upper_result_next, bottom_result_next} = product; // RULE7
                end
                // Accumulate into the 64-bit pair
                mau_pkg::MAU_OP_ACC, mau_pkg::MAU_OP_ACCU: begin
                    pair_write = 1'b1;
                    {upper_result_next, bottom_result_next} = pair_sum; // RULE5
                end
                // Deduct from the 64-bit pair
                mau_pkg::MAU_OP_DEDUCT, mau_pkg::MAU_OP_DEDUCTU: begin
                    pair_write = 1'b1;
                    {upper_result_next, bottom_result_next} = pair_diff; // RULE6
                end
                // Direct loads change one word and keep the other
                mau_pkg::MAU_OP_LOAD_UPPER: begin
                    pair_write = 1'b1;
                    upper_result_next = i_req.src_a;
                end
                mau_pkg::MAU_OP_LOAD_BOTTOM: begin
                    pair_write = 1'b1;
                    bottom_result_next = i_req.src_a;
                end
                // Moves and direct products leave the pair alone
                default: begin
                    pair_write = 1'b0;
                end
            endcase
        end
    end

    // Pair storage
    // Reset clears both words, so a move straight after reset reads zero
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            upper_result_reg <= mau_pkg::RESULT_RESET;
            bottom_result_reg <= mau_pkg::RESULT_RESET;
        end else if (pair_write) begin
            upper_result_reg <= upper_result_next; // RULE1
            bottom_result_reg <= bottom_result_next; // RULE1
        end
    end

    assign o_upper_result = upper_result_reg;
    assign o_bottom_result = bottom_result_reg;

    ////////////////////////////////////////////////////////////////////////////
    // General register write-back
    ////////////////////////////////////////////////////////////////////////////

    // Registered write-back, one cycle after the request; moves see the
    // pair as it stood before this cycle's update
    // Dest follows every request; only valid marks a real register write
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_wb <= '0;
        end else begin
            o_wb.valid <= 1'b0;
            o_wb.dest <= i_req.dest; // RULE4
            case (op)
                // Low product word goes straight to the register file
                mau_pkg::MAU_OP_PRODUCT_GPR: begin
                    o_wb.valid <= 1'b1; // RULE3
                    o_wb.data <= product[31:0]; // RULE3
                end
                // Moves copy one word of the pair
                mau_pkg::MAU_OP_MOVE_UPPER: begin
                    o_wb.valid <= 1'b1;
                    o_wb.data <= upper_result_reg; // RULE2
                end
                // Bottom word, same timing as the upper move
                mau_pkg::MAU_OP_MOVE_BOTTOM: begin
                    o_wb.valid <= 1'b1;
                    o_wb.data <= bottom_result_reg; // RULE2
                end
                // Pair operations and divides never write a register
                default: begin
                    o_wb.valid <= 1'b0;
                end
            endcase
        end
    end
endmodule : mau_unit

/* verification/mau_gpr_model.sv */
// General register file model fed by the write-back port.
// Assumes write-back is a one-cycle pulse on the core clock.
`timescale 1ns/1ps
module mau_gpr_model (
    input wire logic i_core_clk,
    input wire mau_pkg::mau_wb_type i_wb
);
    logic [31:0] regs [32];
    initial regs = '{default: 32'h0};
    // Any index is taken, so successive writes land apart
    always @(posedge i_core_clk) begin
        if (i_wb.valid === 1'b1) begin
            regs[i_wb.dest] <= i_wb.data;
        end
    end
endmodule : mau_gpr_model

/* verification/mau_unit_checker.sv */
// Checker: result pair, write-back and divide timing of the datapath.
// Assumes it is bound to mau_unit and sees only that module's ports.
`timescale 1ns/1ps
module mau_unit_checker (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic i_req_valid,
    input wire mau_pkg::mau_req_type i_req,
    input wire logic o_busy,
    input wire mau_pkg::mau_wb_type o_wb,
    input wire logic [31:0] o_upper_result,
    input wire logic [31:0] o_bottom_result
);
    logic go;
    logic [63:0] pair;
    logic [63:0] prod;
    logic [63:0] sprod;
    // Skip takes during a divide; the pair may change under them
    assign go = i_req_valid && !o_busy;
    assign pair = {o_upper_result, o_bottom_result};
    assign prod = {32'h0, i_req.src_a} * {32'h0, i_req.src_b};
    // Signed product: both operands sign-extended, low 64 bits kept
    assign sprod = {{32{i_req.src_a[31]}}, i_req.src_a} * {{32{i_req.src_b[31]}}, i_req.src_b};
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);
    ////////////////////////////////////////////////////////////////
    a_multu_pair: assert property (go && i_req.op == mau_pkg::MAU_OP_MULTU |=> pair == $past(prod))
        else $error("unsigned product not in pair");
    a_mult_no_wb: assert property (go && i_req.op == mau_pkg::MAU_OP_MULT |=> !o_wb.valid)
        else $error("multiply wrote a general register");
    a_move_upper: assert property (go && i_req.op == mau_pkg::MAU_OP_MOVE_UPPER |=> o_wb.valid
        && o_wb.data == $past(o_upper_result) && o_wb.dest == $past(i_req.dest)) else $error("bad upper move");
    a_move_bottom: assert property (go && i_req.op == mau_pkg::MAU_OP_MOVE_BOTTOM |=> o_wb.valid
        && o_wb.data == $past(o_bottom_result) && o_wb.dest == $past(i_req.dest)) else $error("bad bottom move");
    a_gpr_product: assert property (go && i_req.op == mau_pkg::MAU_OP_PRODUCT_GPR |=> o_wb.valid
        && o_wb.data == $past(prod[31:0]) && o_wb.dest == $past(i_req.dest) && $stable(pair))
        else $error("bad direct product write");
    a_accu_sum: assert property (go && i_req.op == mau_pkg::MAU_OP_ACCU |=> pair == $past(pair) + $past(prod))
        else $error("bad accumulate");
    a_deductu_diff: assert property (go && i_req.op == mau_pkg::MAU_OP_DEDUCTU |=>
        pair == $past(pair) - $past(prod)) else $error("bad deduct");
    a_mult_pair: assert property (go && i_req.op == mau_pkg::MAU_OP_MULT |=> pair == $past(sprod))
        else $error("signed product not in pair");
    a_acc_sum: assert property (go && i_req.op == mau_pkg::MAU_OP_ACC |=>
        pair == $past(pair) + $past(sprod)) else $error("bad signed accumulate");
    a_deduct_diff: assert property (go && i_req.op == mau_pkg::MAU_OP_DEDUCT |=>
        pair == $past(pair) - $past(sprod)) else $error("bad signed deduct");
    a_div_length: assert property ($rose(o_busy) |-> ##33 $fell(o_busy))
        else $error("divide busy length wrong");
    a_div_busy: assert property ($rose(o_busy) |-> o_busy [*8])
        else $error("divide busy too short");
    a_divu_result: assert property ($fell(o_busy) && i_req.op == mau_pkg::MAU_OP_DIVU |=>
        o_bottom_result == $past(i_req.src_a) / $past(i_req.src_b)
        && o_upper_result == $past(i_req.src_a) % $past(i_req.src_b)) else $error("bad unsigned divide");
endmodule : mau_unit_checker

bind mau_unit mau_unit_checker u_chk (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_req_valid(i_req_valid),
    .i_req(i_req), .o_busy(o_busy), .o_wb(o_wb), .o_upper_result(o_upper_result), .o_bottom_result(o_bottom_result));

/* verification/tb_multiply_accumulate_unit.sv */
// Testbench: fixed rotation of operations on pseudo-random operands against a behavioural pair model.
// Assumes mau_unit, the register file model and the bound checker.
`timescale 1ns/1ps
module tb_multiply_accumulate_unit;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    mau_pkg::mau_req_type req = '0;
    logic busy;
    mau_pkg::mau_wb_type wb;
    logic [31:0] upper;
    logic [31:0] bottom;
    logic [31:0] seed = 32'h8a51;
    logic [31:0] a;
    logic [31:0] b;
    logic [63:0] m_pair = 64'h0;
    logic [31:0] m_gpr [32];
    int n_errors = 0;
    int n_tests = 0;
    mau_pkg::mau_op_type ops [$] = '{mau_pkg::MAU_OP_MULT, mau_pkg::MAU_OP_LOAD_UPPER, mau_pkg::MAU_OP_MOVE_UPPER,
        mau_pkg::MAU_OP_LOAD_BOTTOM, mau_pkg::MAU_OP_MOVE_BOTTOM, mau_pkg::MAU_OP_ACC, mau_pkg::MAU_OP_DEDUCT,
        mau_pkg::MAU_OP_MULTU, mau_pkg::MAU_OP_ACCU, mau_pkg::MAU_OP_DEDUCTU, mau_pkg::MAU_OP_PRODUCT_GPR,
        mau_pkg::MAU_OP_DIV, mau_pkg::MAU_OP_DIVU};
    always #50 clk = ~clk;
    mau_unit dut (.i_core_clk(clk), .i_sys_rst(rst), .i_req_valid(req_valid), .i_req(req), .o_busy(busy),
        .o_wb(wb), .o_upper_result(upper), .o_bottom_result(bottom));
    mau_gpr_model u_gpr (.i_core_clk(clk), .i_wb(wb));
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic finish_test();
        $display("Errors %0d of %0d checks", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test
    // Hold the request until busy drops, then model and compare
    task automatic run_op(input mau_pkg::mau_op_type op, input logic [31:0] x, input logic [31:0] y,
        input logic [4:0] d);
        int k;
        logic [63:0] sp;
        logic [63:0] up;
        k = 0;
        sp = longint'($signed(x)) * longint'($signed(y));
        up = {32'h0, x} * {32'h0, y};
        @(posedge clk);
        #1;
        req = '{op, x, y, d};
        req_valid = 1'b1;
        // Busy is settled mid-cycle; the request is taken at the next edge
        do begin
            @(negedge clk);
            k++;
        end while (busy !== 1'b0 && k < 60);
        if (k >= 60) begin
            n_errors++;
            $display("BAD busy expected 0 seen %b", busy);
        end
        @(posedge clk);
        #1;
        req_valid = 1'b0;
        case (op)
            mau_pkg::MAU_OP_MULT: m_pair = sp;
            mau_pkg::MAU_OP_MULTU: m_pair = up;
            mau_pkg::MAU_OP_ACC: m_pair += sp;
            mau_pkg::MAU_OP_ACCU: m_pair += up;
            mau_pkg::MAU_OP_DEDUCT: m_pair -= sp;
            mau_pkg::MAU_OP_DEDUCTU: m_pair -= up;
            mau_pkg::MAU_OP_PRODUCT_GPR: m_gpr[d] = sp[31:0];
            mau_pkg::MAU_OP_MOVE_UPPER: m_gpr[d] = m_pair[63:32];
            mau_pkg::MAU_OP_MOVE_BOTTOM: m_gpr[d] = m_pair[31:0];
            mau_pkg::MAU_OP_DIV: m_pair = {32'($signed(x) % $signed(y)), 32'($signed(x) / $signed(y))};
            mau_pkg::MAU_OP_DIVU: m_pair = {x % y, x / y};
            mau_pkg::MAU_OP_LOAD_UPPER: m_pair[63:32] = x;
            mau_pkg::MAU_OP_LOAD_BOTTOM: m_pair[31:0] = x;
            default: ;
        endcase
        @(posedge clk);
        #1;
        check("idle", 64'h0, {63'h0, busy});
        check("pair", m_pair, {upper, bottom});
        check("gpr", {32'h0, m_gpr[d]}, {32'h0, u_gpr.regs[d]});
    endtask : run_op
    ////////////////////////////////////////////////////////////////
    // Divisors kept small and nonzero: zero and overflow are design choices
    initial begin
        m_gpr = '{default: 32'h0};
        repeat (12) @(posedge clk);
        #1;
        rst = 1'b0;
        check("reset", 64'h0, {upper, bottom});
        for (int i = 0; i < 52; i++) begin
            seed = lfsr(seed);
            a = seed;
            seed = lfsr(seed);
            b = (i % 13 > 10) ? {24'h0, seed[7:0] | 8'h01} : seed;
            run_op(ops[i % 13], a, b, seed[12:8]);
        end
        finish_test();
    end
    // Watchdog well beyond 52 operations of at most 40 cycles
    initial begin
        #(100 * 5000);
        n_errors++;
        finish_test();
    end
endmodule : tb_multiply_accumulate_unit
